// [dsam_consts.svh]
`ifndef DSAM_CONSTS_SVH
`define DSAM_CONSTS_SVH
// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define DSAM_OFF_PAGE      4'h0
`define DSAM_OFF_CTRL      4'h4
`define DSAM_OFF_STATUS    4'h8
`define DSAM_OFF_YBASE     4'hc
`define DSAM_CTRL_WIN_BIT  0
`define DSAM_PAGE_RESET    8'h00
// ---------------------------------------------------------------
// Address layout and timing
// ---------------------------------------------------------------
`define DSAM_Y_START       16'h1800
`define DSAM_Y_END         16'h27ff
`define DSAM_RAM_END       16'h27ff
`define DSAM_WIN_BIT       15
`define DSAM_STEP_BYTE     16'h0001
`define DSAM_STEP_WORD     16'h0002
`define DSAM_EXTRA_ONE     2'h1
`define DSAM_EXTRA_TWO     2'h2
`endif

// [dsam_pkg.sv]
`default_nettype none
package dsam_pkg;
   // Data access request from the address generation units
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        byte_op;
      logic        dual_mac;
      logic        bit_rev;
      logic [15:0] ea;
      logic [15:0] wdata;
   } dsam_xreq_t;
   // Instruction context for extra-cycle accounting
   typedef struct packed {
      logic prefetch_mac;
      logic is_move;
      logic in_repeat;
      logic rep_first;
      logic rep_last;
      logic rep_irq_edge;
      logic table_op;
   } dsam_ctx_t;
   typedef enum logic [2:0] {
      DSAM_IDLE = 3'b001,
      DSAM_READ = 3'b010,
      DSAM_DONE = 3'b100
   } dsam_bus_t;
endpackage
`default_nettype wire

// [dsam_map.sv]
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dsam_consts.svh"
module dsam_map #(
   parameter int RAM_WORDS = 5120       // Implemented RAM words
) (
   input  wire logic             clk_i,          // Core clock
   input  wire logic             rstn_i,         // Async reset, low
   input  wire logic [3:0]       avs_address,    // Byte address
   input  wire logic             avs_read,       // Read request
   input  wire logic             avs_write,      // Write request
   input  wire logic [31:0]      avs_writedata,  // Write data
   input  wire logic [3:0]       avs_byteenable, // Byte lanes
   output logic [31:0]           avs_readdata,   // Read data
   output logic                  avs_waitrequest,// Stall
   input  wire dsam_pkg::dsam_xreq_t xreq_i,     // X access
   input  wire dsam_pkg::dsam_ctx_t  ctx_i,      // Instruction context
   input  wire logic             y_valid_i,      // Y prefetch read
   input  wire logic [15:0]      y_ea_i,         // Y effective addr
   input  wire logic             table_op_i,     // Table instr active
   output logic [15:0]           x_rdata_o,      // X read data
   output logic [15:0]           y_rdata_o,      // Y read data
   output logic                  prog_rd_o,      // Program read
   output logic [22:0]           prog_addr_o,    // Program address
   input  wire logic [23:0]      prog_rdata_i,   // Program word
   output logic                  ram_we_o,       // Data RAM write
   output logic [1:0]            ram_be_o,       // Lane strobes
   output logic [14:0]           ram_waddr_o,    // Word address
   output logic [15:0]           ram_wdata_o,    // Write data
   output logic [14:0]           ram_xaddr_o,    // X read word addr
   input  wire logic [15:0]      ram_xrdata_i,   // X RAM read word
   output logic [14:0]           ram_yaddr_o,    // Y read word addr
   input  wire logic [15:0]      ram_yrdata_i,   // Y RAM read word
   output logic [1:0]            extra_cyc_o,    // Added stall cycles
   output logic [15:0]           addr_step_o,    // Post-modify step
   output logic                  addr_trap_o     // Address error trap
);
   import dsam_pkg::*;

   // All checks below run on the core clock and sleep in reset
   default clocking cb_core @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   // Elaboration guard: RAM must fit below the window half
   if (RAM_WORDS < 1 || RAM_WORDS > 16384) begin : g_bad_ram
      $error("RAM_WORDS out of range");
   end

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [7:0]  page_reg;
   logic        win_en_reg;
   logic        trap_seen_reg;
   logic        trap_seen_next;
   logic        bus_rd_reg;

   // Page and control writes; single-cycle write, no wait
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         page_reg   <= `DSAM_PAGE_RESET;
         win_en_reg <= 1'b0;
      end else if (avs_write && avs_byteenable[0]) begin
         if (avs_address == `DSAM_OFF_PAGE)
            page_reg <= avs_writedata[7:0];
         if (avs_address == `DSAM_OFF_CTRL)
            win_en_reg <= avs_writedata[`DSAM_CTRL_WIN_BIT];
      end
   end

   // Reads take one wait cycle so readdata is registered
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i)
         bus_rd_reg <= 1'b0;
      else
         bus_rd_reg <= avs_read && !bus_rd_reg;
   end
   assign avs_waitrequest = avs_read && !bus_rd_reg;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read && !bus_rd_reg) begin
         case (avs_address)
            `DSAM_OFF_PAGE:   avs_readdata <= {24'h0, page_reg};
            `DSAM_OFF_CTRL:   avs_readdata <= {31'h0, win_en_reg};
            `DSAM_OFF_STATUS: avs_readdata <= {31'h0, trap_seen_reg};
            // Boundary is read-only: hardware fixed
            `DSAM_OFF_YBASE:  avs_readdata <= {`DSAM_Y_END,
                                               `DSAM_Y_START};
            default:          avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   logic        upper;
   logic        win_hit;
   logic        in_y;
   logic        in_ram;
   logic        x_ok;
   logic        mis;
   logic        x_trap;
   logic        y_in;
   logic        y_ok;
   logic        y_trap;
   logic [15:0] word;

   assign upper   = xreq_i.ea[`DSAM_WIN_BIT];
   // Table ops suspend the window; upper half never counts as Y
   assign win_hit = upper && win_en_reg && !table_op_i;
   assign in_y    = !upper && xreq_i.ea >= `DSAM_Y_START &&
                    xreq_i.ea <= `DSAM_Y_END;
   assign in_ram  = xreq_i.ea[15:1] < 15'(RAM_WORDS);
   // Dual-operand X pointer reads may not reach Y; others see linear space
   assign x_ok    = in_ram && !(xreq_i.dual_mac && in_y && !xreq_i.write);
   assign mis     = !xreq_i.byte_op && xreq_i.ea[0];
   assign x_trap  = xreq_i.valid && (mis || (!win_hit && !in_ram));
   assign y_in    = y_ea_i >= `DSAM_Y_START && y_ea_i <= `DSAM_Y_END;
   assign y_ok    = y_in && !y_ea_i[0];
   assign y_trap  = y_valid_i && y_ea_i[0];

   // Program address: page over low 15 bits of the address
   assign prog_rd_o   = xreq_i.valid && !xreq_i.write && win_hit;
   assign prog_addr_o = {page_reg, xreq_i.ea[14:0]};

   // Read path word selection; zero when out of region
   always_comb begin
      if (win_hit)
         word = prog_rdata_i[15:0];
      else if (x_ok)
         word = ram_xrdata_i;
      else
         word = 16'h0000;
   end

   assign ram_xaddr_o = xreq_i.ea[15:1];
   assign ram_yaddr_o = y_ea_i[15:1];

   // Registered read data; byte reads land on the low lane
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         x_rdata_o <= 16'h0000;
         y_rdata_o <= 16'h0000;
      end else begin
         if (xreq_i.valid && !xreq_i.write)
            x_rdata_o <= xreq_i.byte_op ?
                         {8'h00, xreq_i.ea[0] ? word[15:8] : word[7:0]}
                         : word;
         if (y_valid_i)
            y_rdata_o <= y_ok ? ram_yrdata_i : 16'h0000;
      end
   end

   // ---------------------------------------------------------------
   // Write path: X bus only, Y never writes
   // ---------------------------------------------------------------
   // Window area and misaligned words are not stored
   assign ram_we_o    = xreq_i.valid && xreq_i.write && !win_hit &&
                        in_ram && !mis;
   assign ram_be_o    = xreq_i.byte_op ?
                        (xreq_i.ea[0] ? 2'b10 : 2'b01) : 2'b11;
   assign ram_waddr_o = xreq_i.ea[15:1];
   assign ram_wdata_o = xreq_i.byte_op ?
                        {2{xreq_i.wdata[7:0]}} : xreq_i.wdata;
   // Bit reverse is not used; step follows operand size only; modulo stays in the AGU
   assign addr_step_o = xreq_i.byte_op ? `DSAM_STEP_BYTE
                                       : `DSAM_STEP_WORD;

   assign addr_trap_o = x_trap || y_trap;

   // Trap history for software, hardware set wins over clear
   always_comb begin
      trap_seen_next = trap_seen_reg;
      if (avs_write && avs_address == `DSAM_OFF_STATUS &&
          avs_writedata[0])
         trap_seen_next = 1'b0;
      if (addr_trap_o)
         trap_seen_next = 1'b1;
   end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i)
         trap_seen_reg <= 1'b0;
      else
         trap_seen_reg <= trap_seen_next;
   end

   // ---------------------------------------------------------------
   // Extra cycles for window accesses
   // ---------------------------------------------------------------
   always_comb begin
      extra_cyc_o = 2'h0;
      if (xreq_i.valid && win_hit) begin
         if (ctx_i.in_repeat) begin
            if (ctx_i.rep_first || ctx_i.rep_last || ctx_i.rep_irq_edge)
               extra_cyc_o = `DSAM_EXTRA_TWO;
         end else if (ctx_i.prefetch_mac || ctx_i.is_move)
            extra_cyc_o = `DSAM_EXTRA_ONE;
         else
            extra_cyc_o = `DSAM_EXTRA_TWO;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Multi-step behaviours are built from these sequences
   // First cycle of a register read: the stall cycle
   sequence s_rd_first;
      avs_read && !bus_rd_reg;
   endsequence

   // First read cycle aimed at the fixed boundary word
   sequence s_rd_bound;
      s_rd_first ##0 (avs_address == `DSAM_OFF_YBASE);
   endsequence

   // Byte-lane-0 write to the page register
   sequence s_page_wr;
      avs_write && avs_byteenable[0] &&
      avs_address == `DSAM_OFF_PAGE;
   endsequence

   // Software clear of the trap flag with no new trap pending
   sequence s_trap_clr;
      avs_write && avs_address == `DSAM_OFF_STATUS &&
      avs_writedata[0] && !addr_trap_o;
   endsequence

   // Word read through the program window
   sequence s_win_word_rd;
      prog_rd_o && !xreq_i.byte_op;
   endsequence

   // Window access outside a repeat loop
   sequence s_win_plain;
      xreq_i.valid && win_hit && !ctx_i.in_repeat;
   endsequence

   // Window access at a repeat loop boundary iteration
   sequence s_win_rep_edge;
      xreq_i.valid && win_hit && ctx_i.in_repeat &&
      (ctx_i.rep_first || ctx_i.rep_last || ctx_i.rep_irq_edge);
   endsequence

   // Page register supplies the top program address bits
   chk_win_addr: assert property (
      prog_rd_o |-> prog_addr_o[22:15] == page_reg)
      else $error("window page wrong");

   // Low program address bits follow the data address
   chk_win_low: assert property (
      prog_rd_o |-> prog_addr_o[14:0] == xreq_i.ea[14:0])
      else $error("window low address wrong");

   // Table instructions must see plain data space
   chk_table_off: assert property (
      table_op_i |-> !prog_rd_o)
      else $error("window active in table op");

   // Misaligned word writes trap and never reach the RAM
   chk_no_mis_wr: assert property (
      (xreq_i.valid && mis) |-> (!ram_we_o && addr_trap_o))
      else $error("misaligned write stored");

   // Misaligned word reads trap as well
   chk_mis_rd: assert property (
      (xreq_i.valid && !xreq_i.write && mis) |-> addr_trap_o)
      else $error("misaligned read not trapped");

   // A byte write touches exactly one lane
   chk_byte_lane: assert property (
      (ram_we_o && xreq_i.byte_op) |-> $onehot(ram_be_o))
      else $error("byte write strobes both lanes");

   // The lane written matches address bit zero
   chk_lane_pick: assert property (
      (ram_we_o && xreq_i.byte_op) |->
         ram_be_o[1] == xreq_i.ea[0])
      else $error("byte write on wrong lane");

   // Y pointer outside the Y block reads zero
   chk_y_zero: assert property (
      (y_valid_i && !y_in) |=> y_rdata_o == 16'h0000)
      else $error("Y outside region not zero");

   // Y reads inside the region return the RAM word
   chk_y_word: assert property (
      (y_valid_i && y_ok) |=> y_rdata_o == $past(ram_yrdata_i))
      else $error("Y read data wrong");

   // Odd Y addresses are byte accesses: refused with a trap
   chk_y_byte: assert property (
      (y_valid_i && y_ea_i[0]) |-> addr_trap_o)
      else $error("Y byte access not trapped");

   // X pointers of a dual-operand read may not reach Y
   chk_x_mac_y: assert property (
      (xreq_i.valid && !xreq_i.write && xreq_i.dual_mac && in_y)
      |=> x_rdata_o == 16'h0000)
      else $error("X pointer read Y data");

   // Other instructions see Y through the linear X space
   chk_linear_x: assert property (
      (xreq_i.valid && !xreq_i.write && !xreq_i.dual_mac &&
       !xreq_i.byte_op && !upper && in_ram)
      |=> x_rdata_o == $past(ram_xrdata_i))
      else $error("linear X read wrong");

   // Upper half is never decoded as Y
   chk_upper_x: assert property (
      upper |-> !in_y)
      else $error("upper half decoded as Y");

   // Post-modify step scales with operand size
   chk_step_size: assert property (
      addr_step_o == (xreq_i.byte_op ? 16'h0001 : 16'h0002))
      else $error("step size wrong");

   // Middle repeat iterations run without stall
   chk_rep_single: assert property (
      (ctx_i.in_repeat && !ctx_i.rep_first && !ctx_i.rep_last &&
       !ctx_i.rep_irq_edge) |-> extra_cyc_o == 2'h0)
      else $error("repeat middle stalled");

   // Boundary iterations of a repeat loop pay two cycles
   chk_rep_edge: assert property (
      s_win_rep_edge |-> extra_cyc_o == `DSAM_EXTRA_TWO)
      else $error("repeat boundary not stalled");

   // Moves and prefetching multiply-accumulates pay one cycle
   chk_extra_one: assert property (
      s_win_plain ##0 (ctx_i.prefetch_mac || ctx_i.is_move)
      |-> extra_cyc_o == `DSAM_EXTRA_ONE)
      else $error("move window stall wrong");

   // Every other instruction pays two cycles
   chk_extra_two: assert property (
      s_win_plain ##0 (!ctx_i.prefetch_mac && !ctx_i.is_move)
      |-> extra_cyc_o == `DSAM_EXTRA_TWO)
      else $error("other window stall wrong");

   // No stall is added without a window access
   chk_no_extra: assert property (
      !(xreq_i.valid && win_hit) |-> extra_cyc_o == 2'h0)
      else $error("stall without window access");

   // Window writes never reach the data RAM
   chk_wr_upper: assert property (
      (xreq_i.valid && win_hit) |-> !ram_we_o)
      else $error("window write reached RAM");

   // Window off: upper half never goes to program memory
   chk_win_off: assert property (
      (xreq_i.valid && upper && !win_en_reg) |-> !prog_rd_o)
      else $error("window used while disabled");

   // Only the low 16 program bits come back
   chk_win_low16: assert property (
      s_win_word_rd |=> x_rdata_o == $past(prog_rdata_i[15:0]))
      else $error("window read data wrong");

   // Byte reads leave the high lane clear
   chk_byte_low: assert property (
      (xreq_i.valid && !xreq_i.write && xreq_i.byte_op)
      |=> x_rdata_o[15:8] == 8'h00)
      else $error("byte read high lane set");

   // RAM writes only come from the X write request
   chk_we_x: assert property (
      ram_we_o |-> (xreq_i.valid && xreq_i.write))
      else $error("RAM write without X write");

   // Unimplemented addresses trap
   chk_unimpl_trap: assert property (
      (xreq_i.valid && !win_hit && !in_ram) |-> addr_trap_o)
      else $error("unimplemented access not trapped");

   // Unimplemented addresses read zero
   chk_unimpl_zero: assert property (
      (xreq_i.valid && !xreq_i.write && !win_hit && !in_ram)
      |=> x_rdata_o == 16'h0000)
      else $error("unimplemented read not zero");

   // A trap is remembered for software
   chk_trap_keep: assert property (
      addr_trap_o |=> trap_seen_reg)
      else $error("trap not recorded");

   // A clear with no new trap empties the flag
   chk_trap_clr: assert property (
      s_trap_clr |=> !trap_seen_reg)
      else $error("trap flag not cleared");

   // Register reads stall one cycle, then answer
   chk_rd_stall: assert property (
      s_rd_first |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read stall wrong");

   // Boundary word reads back the fixed limits
   chk_bound_fix: assert property (
      s_rd_bound |=> avs_readdata == {`DSAM_Y_END, `DSAM_Y_START})
      else $error("boundary word wrong");

   // Page writes land in the page register
   chk_page_wr: assert property (
      s_page_wr |=> page_reg == $past(avs_writedata[7:0]))
      else $error("page write lost");
endmodule
`default_nettype wire

// [dsam_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Program flash and data RAM seen from the map block
// ---------------------------------------------------------------
module dsam_mem_model (
   input  wire logic        prog_rd_i,    // Program read strobe
   input  wire logic [22:0] prog_addr_i,  // Program address
   output logic [23:0]      prog_rdata_o, // Program word
   input  wire logic [14:0] ram_xaddr_i,  // X word address
   output logic [15:0]      ram_xrdata_o, // X word
   input  wire logic [14:0] ram_yaddr_i,  // Y word address
   output logic [15:0]      ram_yrdata_o  // Y word
);
   logic [23:0] word;
   // Upper byte holds an illegal opcode; an idle bus shows the inverse
   assign word = {8'hff, prog_addr_i[15:0]};
   assign prog_rdata_o = prog_rd_i ? word : ~word;
   // Word content tracks its address so lane mix-ups show
   assign ram_xrdata_o = {1'b1, ram_xaddr_i};
   assign ram_yrdata_o = {1'b1, ram_yaddr_i};
endmodule
`default_nettype wire

// [dsam_map_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module dsam_map_tb;
   import dsam_pkg::*;
   logic clk_i, rstn_i, rd, wr, yv, tbl, prd, we, wt, trap;
   logic [3:0] adr;
   logic [31:0] wdat, rdat, rdat_q;
   logic [15:0] yea, xrd, yrd, step;
   logic [14:0] xa, ya, wa;
   logic [22:0] pa;
   logic [23:0] pd;
   logic [15:0] xw, yw, wd;
   logic [1:0] be, ex;
   dsam_xreq_t xreq;
   dsam_ctx_t ctx;
   int num_errors = 0;
   int check_count = 0;
   dsam_map dsam_map_i (.clk_i(clk_i), .rstn_i(rstn_i),
      .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
      .avs_waitrequest(wt), .xreq_i(xreq), .ctx_i(ctx), .y_valid_i(yv),
      .y_ea_i(yea), .table_op_i(tbl), .x_rdata_o(xrd), .y_rdata_o(yrd),
      .prog_rd_o(prd), .prog_addr_o(pa), .prog_rdata_i(pd),
      .ram_we_o(we), .ram_be_o(be), .ram_waddr_o(wa), .ram_wdata_o(wd),
      .ram_xaddr_o(xa), .ram_xrdata_i(xw), .ram_yaddr_o(ya),
      .ram_yrdata_i(yw), .extra_cyc_o(ex), .addr_step_o(step),
      .addr_trap_o(trap));
   dsam_mem_model dsam_mem_model_i (.prog_rd_i(prd), .prog_addr_i(pa),
      .prog_rdata_o(pd), .ram_xaddr_i(xa), .ram_xrdata_o(xw),
      .ram_yaddr_i(ya), .ram_yrdata_o(yw));
   // ---------------------------------------------------------------
   // Clock, compare and closing
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task summarize();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Avalon master: hold until waitrequest is seen low at an edge
   task av(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      rd <= ~w;
      wr <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (wt !== 1'b0);
      rdat_q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task rchk(input logic [3:0] a, input logic [31:0] e);
      av(1'b0, a, 32'h0);
      chk(rdat_q, e);
   endtask
   // Core access: combinational outputs checked before xend
   task xacc(input logic w, b, d, input logic [15:0] ea, input logic [6:0] c);
      @(posedge clk_i);
      xreq <= '{1'b1, w, b, d, 1'b0, ea, 16'h00a5};
      ctx <= dsam_ctx_t'(c);
      @(negedge clk_i);
   endtask
   task xend();
      @(posedge clk_i);
      xreq.valid <= 1'b0;
      @(negedge clk_i);
   endtask
   // Watchdog well beyond the fewer than a hundred cycles the tests need
   initial begin
      repeat (4000) @(posedge clk_i);
      num_errors++;
      summarize();
   end
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   logic [6:0] cx [7] = '{7'h40, 7'h20, 7'h00, 7'h18, 7'h10, 7'h14, 7'h12};
   logic [1:0] ce [7] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h2, 2'h2};
   initial begin
      rstn_i = 1'b0; rd = 1'b0; wr = 1'b0; adr = 4'h0; wdat = 32'h0;
      yv = 1'b0; yea = 16'h0; tbl = 1'b0; xreq = '0; ctx = '0;
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
      rchk(4'h0, 32'h0);
      rchk(4'h4, 32'h0);
      av(1'b1, 4'hc, 32'h0);
      rchk(4'hc, 32'h27ff1800);
      rchk(4'h2, 32'h0);
      av(1'b1, 4'h0, 32'h5b);
      av(1'b1, 4'h4, 32'h1);
      rchk(4'h0, 32'h5b);
      // Window read: page supplies the top address bits
      xacc(1'b0, 1'b0, 1'b0, 16'h8246, 7'h20);
      chk(prd, 1'b1);
      chk(pa, {8'h5b, 15'h0246});
      chk(step, 16'h2);
      xend();
      chk(xrd, 16'h8246);
      for (int i = 0; i < 7; i++) begin
         xacc(1'b0, 1'b0, 1'b0, 16'h8246, cx[i]);
         chk(ex, ce[i]);
      end
      @(posedge clk_i) tbl <= 1'b1;
      xacc(1'b0, 1'b0, 1'b0, 16'h8246, 7'h20);
      chk(prd, 1'b0);
      @(posedge clk_i) tbl <= 1'b0;
      xacc(1'b0, 1'b0, 1'b1, 16'h8246, 7'h40);
      chk(prd, 1'b1);
      av(1'b1, 4'h4, 32'h0);
      xacc(1'b0, 1'b0, 1'b0, 16'h8246, 7'h20);
      chk({prd, trap}, 2'b01);
      xend();
      chk(xrd, 16'h0);
      rchk(4'h8, 32'h1);
      av(1'b1, 4'h8, 32'h1);
      rchk(4'h8, 32'h0);
      xacc(1'b0, 1'b0, 1'b1, 16'h1800, 7'h40);
      xend();
      chk(xrd, 16'h0);
      xacc(1'b0, 1'b0, 1'b0, 16'h1800, 7'h20);
      xend();
      chk(xrd, 16'h8c00);
      // Y path: a Y address returns data, an X address returns zero
      @(posedge clk_i);
      yv <= 1'b1;
      yea <= 16'h1800;
      @(posedge clk_i);
      yea <= 16'h0100;
      @(negedge clk_i);
      chk(yrd, 16'h8c00);
      @(posedge clk_i);
      yv <= 1'b0;
      @(negedge clk_i);
      chk(yrd, 16'h0);
      // Odd Y address is a byte access and must trap
      @(posedge clk_i);
      yv <= 1'b1;
      yea <= 16'h1801;
      @(negedge clk_i);
      chk(trap, 1'b1);
      @(posedge clk_i);
      yv <= 1'b0;
      xacc(1'b0, 1'b1, 1'b0, 16'h0123, 7'h20);
      chk(step, 16'h1);
      xend();
      chk(xrd, 16'h0080);
      xacc(1'b1, 1'b1, 1'b0, 16'h0123, 7'h20);
      chk({we, be, wa}, {1'b1, 2'b10, 15'h0091});
      chk(wd, 16'ha5a5);
      xacc(1'b1, 1'b0, 1'b0, 16'h0123, 7'h20);
      chk({we, trap}, 2'b01);
      xacc(1'b1, 1'b0, 1'b0, 16'h0124, 7'h20);
      chk({we, be, trap}, 4'b1110);
      xend();
      summarize();
   end
endmodule
`default_nettype wire
